// ==== hdl/mpcs_pkg.sv ====
package mpcs_pkg;
	// clock and the one-second base for all timed waits
	localparam int CLK_PERIOD_NS = 25;
	localparam int SECOND_NS = 1_000_000_000;
	localparam int CYC_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_INTERLOCK = 8'h08;
	localparam logic [7:0] ADDR_START_WAIT = 8'h0C;
	localparam logic [7:0] ADDR_DETECT = 8'h10;
	localparam logic [7:0] ADDR_IN_SEL = 8'h14;
	localparam logic [7:0] ADDR_OUT_SEL = 8'h18;
	localparam logic [7:0] ADDR_RELAY_SEL = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	// field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_INVRST_BIT = 1;
	localparam int CFG_AUX_LSB = 0;
	localparam int CFG_SCHEME_LSB = 4;
	localparam int ST_MAINS_LSB = 0;
	localparam int ST_DRIVE_LSB = 4;
	localparam int ST_DRV_EN_BIT = 8;
	localparam int ST_PAUSE_BIT = 9;
	localparam int ST_STATE_LSB = 12;
	localparam int ST_NMAINS_LSB = 16;
	// reset values and limits
	localparam logic [1:0] AUX_RST = 2'h0;
	localparam logic [6:0] TIME_RST = 7'h01;
	localparam logic [6:0] TIME_MAX = 7'h64;
	localparam logic [13:0] DET_RST = 14'h0001;
	localparam logic [13:0] DET_MAX = 14'h0E10;
	localparam logic [13:0] DET_OFF = 14'h270F;
	localparam logic [7:0] SEL_RST = 8'h00;
	// terminal function codes
	localparam logic [7:0] CODE_ENABLE_IN = 8'h0E;
	localparam logic [7:0] CODE_PAUSE_HI = 8'h46;
	localparam logic [7:0] CODE_PAUSE_LO = 8'hAA;
	localparam logic [7:0] CODE_MAINS_M1 = 8'h47;
	localparam logic [7:0] CODE_MAINS_M4 = 8'h4A;
	localparam logic [7:0] CODE_DRIVE_M1 = 8'h4B;
	localparam logic [7:0] CODE_DRIVE_M4 = 8'h4E;
	localparam logic [7:0] CODE_NEG_M1 = 8'hAB;
	localparam logic [7:0] CODE_NEG_M4 = 8'hB2;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [1:0] {
		SCH_BASIC = 2'b00,
		SCH_ALT = 2'b01,
		SCH_DIRECT = 2'b10,
		SCH_ALT_DIRECT = 2'b11
	} mpcs_scheme_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT_START = 3'b001,
		ST_RUN = 3'b010,
		ST_INTERLOCK = 3'b011,
		ST_PAUSE = 3'b100,
		ST_RAMP_DOWN = 3'b101
	} mpcs_state_t;
endpackage

// ==== hdl/mpcs_sec_timer.sv ====
module mpcs_sec_timer
	import mpcs_pkg::*;
#(
	parameter int CYC = CYC_PER_SEC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic [13:0] secs,
	output logic expired
);
	logic [31:0] cyc_q, cyc_d;
	logic [13:0] sec_q, sec_d;
	logic run_q, run_d;

	// one-cycle pulse once the loaded whole seconds have run out;
	// a held start with zero seconds must not read as expiry
	assign expired = run_q && (sec_q == 14'h0000) && !start;

	// own divider, so a wait never starts mid-second and comes short
	always_comb begin
		cyc_d = cyc_q;
		sec_d = sec_q;
		run_d = run_q;
		if (start) begin
			run_d = 1'b1;
			sec_d = secs;
			cyc_d = 32'h00000000;
		end else if (run_q) begin
			if (sec_q == 14'h0000) begin
				run_d = 1'b0;
			end else if (cyc_q == 32'(CYC - 1)) begin
				cyc_d = 32'h00000000;
				sec_d = sec_q - 14'h0001;
			end else begin
				cyc_d = cyc_q + 32'h00000001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_q <= 32'h00000000;
			sec_q <= 14'h0000;
			run_q <= 1'b0;
		end else begin
			cyc_q <= cyc_d;
			sec_q <= sec_d;
			run_q <= run_d;
		end
	end
endmodule

// ==== hdl/mpcs_sequencer.sv ====
// Our own choices: the AXI4-Lite register port and the placing of the registers.
module mpcs_sequencer
	import mpcs_pkg::*;
#(
	parameter int CYC_SEC = CYC_PER_SEC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic multi_pump_enable_in,
	input wire logic start_cond,
	input wire logic stop_cond,
	input wire logic freq_below_level,
	input wire logic pause_cancel,
	input wire logic drive_standstill,
	output logic mains_contactor_m1,
	output logic mains_contactor_m2,
	output logic mains_contactor_m3,
	output logic mains_contactor_m4,
	output logic drive_contactor_m1,
	output logic drive_contactor_m2,
	output logic drive_contactor_m3,
	output logic drive_contactor_m4,
	output logic drive_output_en,
	output logic output_pause,
	output logic output_terminal,
	output logic relay_option_out
);
	// bus side state
	logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wd, wmask;
	logic [3:0] wstrb_q, wstrb_d;
	logic wr_fire, order_clr;
	// software settings
	logic run_q, run_d;
	logic [1:0] aux_q, aux_d;
	mpcs_scheme_t scheme_q, scheme_d;
	logic [6:0] interlock_q, interlock_d, swait_q, swait_d;
	logic [13:0] detect_q, detect_d;
	logic [7:0] in_sel_q, in_sel_d, out_sel_q, out_sel_d;
	logic [7:0] relay_sel_q, relay_sel_d;
	// sequencer state
	mpcs_state_t state_q, state_d;
	logic [3:0] mains_q, mains_d, drv_q, drv_d;
	logic drv_en_q, drv_en_d, pause_q, pause_d, swap_q, swap_d;
	logic to_mains_q, to_mains_d;
	logic [1:0] idx_q, idx_d, ptr_q, ptr_d, mover_q, mover_d, head;
	logic [1:0] ord_q [4];
	logic [1:0] ord_d [4];
	logic [2:0] cnt_q, cnt_d, nmot, p;
	logic il_start, sw_start, det_start, il_exp, sw_exp, det_exp;
	logic go, running, term_lvl, relay_lvl, term_q, relay_q;

	assign running = (state_q != ST_IDLE);
	assign go = run_q && multi_pump_enable_in
		&& (in_sel_q == CODE_ENABLE_IN);
	assign nmot = {1'b0, aux_q} + 3'h1;
	assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

	// first free motor from a rotating start point
	function automatic logic [2:0] pick(input logic [1:0] from,
		input logic [3:0] busy, input logic [2:0] n);
		logic [1:0] j;
		logic [2:0] r;
		r = 3'b000;
		for (int i = 3; i >= 0; i--) begin
			j = from + 2'(i);
			if ({1'b0, j} < n && !busy[j]) begin
				r = {1'b1, j};
			end
		end
		return r;
	endfunction

	// register read image, shared by reads and strobe merging
	function automatic logic [31:0] reg_rd(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h00000000;
		unique case (a)
			ADDR_CTRL: v[CTRL_RUN_BIT] = run_q;
			ADDR_CONFIG: begin
				v[CFG_AUX_LSB +: 2] = aux_q;
				v[CFG_SCHEME_LSB +: 2] = scheme_q;
			end
			ADDR_INTERLOCK: v[6:0] = interlock_q;
			ADDR_START_WAIT: v[6:0] = swait_q;
			ADDR_DETECT: v[13:0] = detect_q;
			ADDR_IN_SEL: v[7:0] = in_sel_q;
			ADDR_OUT_SEL: v[7:0] = out_sel_q;
			ADDR_RELAY_SEL: v[7:0] = relay_sel_q;
			ADDR_STATUS: begin
				v[ST_MAINS_LSB +: 4] = mains_q;
				v[ST_DRIVE_LSB +: 4] = drv_q;
				v[ST_DRV_EN_BIT] = drv_en_q;
				v[ST_PAUSE_BIT] = pause_q;
				v[ST_STATE_LSB +: 3] = state_q;
				v[ST_NMAINS_LSB +: 3] = cnt_q;
			end
			default: v = 32'h00000000;
		endcase
		return v;
	endfunction

	// bus slave and register writes; one write and one read in flight
	always_comb begin
		{aw_held_d, w_held_d, awaddr_d, wdata_d} =
			{aw_held_q, w_held_q, awaddr_q, wdata_q};
		{wstrb_d, bvalid_d, bresp_d} = {wstrb_q, bvalid_q, bresp_q};
		{rvalid_d, rdata_d, rresp_d} = {rvalid_q, rdata_q, rresp_q};
		{run_d, aux_d} = {run_q, aux_q};
		scheme_d = scheme_q;
		{interlock_d, swait_d, detect_d} = {interlock_q, swait_q, detect_q};
		{in_sel_d, out_sel_d, relay_sel_d} =
			{in_sel_q, out_sel_q, relay_sel_q};
		order_clr = 1'b0;
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{wstrb_q[b]}};
		end
		wd = (reg_rd(awaddr_q) & ~wmask) | (wdata_q & wmask);
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_awvalid && awready_q) begin
			aw_held_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_held_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (wr_fire) begin
			{aw_held_d, w_held_d, bvalid_d} = 3'b001;
			bresp_d = RESP_OKAY;
			unique case (awaddr_q)
				ADDR_CTRL: begin
					run_d = wd[CTRL_RUN_BIT];
					order_clr = wd[CTRL_INVRST_BIT];
				end
				ADDR_CONFIG: begin
					if (running) begin
						bresp_d = RESP_SLVERR;
					end else begin
						aux_d = wd[CFG_AUX_LSB +: 2];
						scheme_d = mpcs_scheme_t'(wd[CFG_SCHEME_LSB +: 2]);
						order_clr = (aux_d != aux_q)
							|| (scheme_d != scheme_q);
					end
				end
				ADDR_INTERLOCK: begin
					if (wd[6:0] > TIME_MAX) begin
						bresp_d = RESP_SLVERR;
					end else begin
						interlock_d = wd[6:0];
					end
				end
				ADDR_START_WAIT: begin
					if (wd[6:0] > TIME_MAX) begin
						bresp_d = RESP_SLVERR;
					end else begin
						swait_d = wd[6:0];
					end
				end
				ADDR_DETECT: begin
					if (wd[13:0] > DET_MAX && wd[13:0] != DET_OFF) begin
						bresp_d = RESP_SLVERR;
					end else begin
						detect_d = wd[13:0];
					end
				end
				ADDR_IN_SEL: in_sel_d = wd[7:0];
				ADDR_OUT_SEL: begin
					if (wd[7:0] >= CODE_NEG_M1 && wd[7:0] <= CODE_NEG_M4) begin
						bresp_d = RESP_SLVERR;
					end else begin
						out_sel_d = wd[7:0];
					end
				end
				ADDR_RELAY_SEL: begin
					if ((wd[7:0] >= CODE_NEG_M1 && wd[7:0] <= CODE_NEG_M4)
						|| wd[7:0] == CODE_PAUSE_LO) begin
						bresp_d = RESP_SLVERR;
					end else begin
						relay_sel_d = wd[7:0];
					end
				end
				ADDR_STATUS: bresp_d = RESP_SLVERR;
				default: bresp_d = RESP_DECERR;
			endcase
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rdata_d = reg_rd(s_axi_araddr);
			rresp_d = (s_axi_araddr <= ADDR_STATUS
				&& s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_DECERR;
		end
		awready_d = !aw_held_d && !bvalid_d;
		wready_d = !w_held_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{awready_q, wready_q, arready_q} <= 3'b000;
			{bvalid_q, rvalid_q, aw_held_q, w_held_q} <= 4'h0;
			{bresp_q, rresp_q} <= 4'h0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			rdata_q <= 32'h00000000;
			run_q <= 1'b0;
			aux_q <= AUX_RST;
			scheme_q <= SCH_BASIC;
			interlock_q <= TIME_RST;
			swait_q <= TIME_RST;
			detect_q <= DET_RST;
			{in_sel_q, out_sel_q, relay_sel_q} <= {3{SEL_RST}};
		end else begin
			{awready_q, wready_q, arready_q} <= {awready_d, wready_d, arready_d};
			{bvalid_q, rvalid_q, aw_held_q, w_held_q} <=
				{bvalid_d, rvalid_d, aw_held_d, w_held_d};
			{bresp_q, rresp_q} <= {bresp_d, rresp_d};
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			rdata_q <= rdata_d;
			run_q <= run_d;
			aux_q <= aux_d;
			scheme_q <= scheme_d;
			interlock_q <= interlock_d;
			swait_q <= swait_d;
			detect_q <= detect_d;
			{in_sel_q, out_sel_q, relay_sel_q} <=
				{in_sel_d, out_sel_d, relay_sel_d};
		end
	end

	// low-frequency detection restarts whenever the condition breaks
	assign det_start = !(state_q == ST_RUN && freq_below_level
		&& detect_q != DET_OFF);

	mpcs_sec_timer #(.CYC(CYC_SEC)) u_interlock (.aclk(aclk),
		.aresetn(aresetn), .start(il_start),
		.secs({7'h00, interlock_q}), .expired(il_exp));
	mpcs_sec_timer #(.CYC(CYC_SEC)) u_start_wait (.aclk(aclk),
		.aresetn(aresetn), .start(sw_start),
		.secs({7'h00, swait_q}), .expired(sw_exp));
	mpcs_sec_timer #(.CYC(CYC_SEC)) u_detect (.aclk(aclk),
		.aresetn(aresetn), .start(det_start), .secs(detect_q),
		.expired(det_exp));

	// motor sequencing; contactors only open before others close
	always_comb begin
		state_d = state_q;
		{mains_d, drv_d, drv_en_d} = {mains_q, drv_q, drv_en_q};
		{pause_d, swap_d, to_mains_d} = {pause_q, swap_q, to_mains_q};
		{idx_d, ptr_d, mover_d, cnt_d} = {idx_q, ptr_q, mover_q, cnt_q};
		ord_d = ord_q;
		{il_start, sw_start} = 2'b00;
		head = ord_q[0];
		p = 3'h0;
		if (order_clr || (!go && running)) begin
			// start off or reset drops every contactor at once
			state_d = ST_IDLE;
			{mains_d, drv_d} = 8'h00;
			{drv_en_d, pause_d, swap_d} = 3'b000;
			cnt_d = 3'h0;
			if (order_clr) begin
				ptr_d = 2'h0;
			end
		end else begin
			unique case (state_q)
				ST_IDLE: if (go) begin
					if (scheme_q == SCH_BASIC) begin
						p = 3'h4;
					end else begin
						p = pick(ptr_q, 4'h0, nmot);
						ptr_d = p[1:0] + 2'h1;
					end
					idx_d = p[1:0];
					drv_d[p[1:0]] = 1'b1;
					if (scheme_q == SCH_BASIC || scheme_q == SCH_ALT) begin
						drv_en_d = 1'b1;
						state_d = ST_RUN;
					end else begin
						sw_start = 1'b1;
						state_d = ST_WAIT_START;
					end
				end
				ST_WAIT_START: if (sw_exp) begin
					drv_en_d = 1'b1;
					state_d = ST_RUN;
				end
				ST_RUN: begin
					if (det_exp) begin
						{drv_en_d, pause_d} = 2'b01;
						state_d = ST_PAUSE;
						if (scheme_q == SCH_ALT) begin
							drv_d[idx_q] = 1'b0;
							swap_d = 1'b1;
						end
					end else if (start_cond && cnt_q < {1'b0, aux_q}) begin
						if (scheme_q == SCH_BASIC || scheme_q == SCH_ALT) begin
							p = pick(idx_q + 2'h1, mains_q | drv_q, nmot);
							mains_d[p[1:0]] = p[2];
							ord_d[cnt_q[1:0]] = p[1:0];
							cnt_d = cnt_q + 3'(p[2]);
						end else begin
							drv_d[idx_q] = 1'b0;
							drv_en_d = 1'b0;
							mover_d = idx_q;
							to_mains_d = 1'b1;
							il_start = 1'b1;
							state_d = ST_INTERLOCK;
						end
					end else if (stop_cond && cnt_q != 3'h0) begin
						if (scheme_q == SCH_ALT_DIRECT) begin
							drv_en_d = 1'b0;
							state_d = ST_RAMP_DOWN;
						end else begin
							mains_d[head] = 1'b0;
							ord_d[0:2] = ord_q[1:3];
							cnt_d = cnt_q - 3'h1;
						end
					end
				end
				ST_INTERLOCK: if (il_exp) begin
					if (to_mains_q) begin
						mains_d[mover_q] = 1'b1;
						ord_d[cnt_q[1:0]] = mover_q;
						cnt_d = cnt_q + 3'h1;
						p = pick(ptr_q, mains_d | drv_q, nmot);
					end else begin
						p = {1'b1, mover_q};
					end
					idx_d = p[1:0];
					ptr_d = p[1:0] + 2'h1;
					drv_d[p[1:0]] = 1'b1;
					sw_start = 1'b1;
					state_d = ST_WAIT_START;
				end
				ST_RAMP_DOWN: if (drive_standstill) begin
					drv_d[idx_q] = 1'b0;
					mains_d[head] = 1'b0;
					mover_d = head;
					ord_d[0:2] = ord_q[1:3];
					cnt_d = cnt_q - 3'h1;
					to_mains_d = 1'b0;
					il_start = 1'b1;
					state_d = ST_INTERLOCK;
				end
				ST_PAUSE: begin
					if (swap_q) begin
						// old motor is tried last, so the duty moves on
						p = pick(idx_q + 2'h1, mains_q, nmot);
						idx_d = p[1:0];
						ptr_d = p[1:0] + 2'h1;
						drv_d[p[1:0]] = 1'b1;
						swap_d = 1'b0;
					end else if (pause_cancel) begin
						{drv_en_d, pause_d} = 2'b10;
						state_d = ST_RUN;
					end
				end
				default: state_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			{mains_q, drv_q} <= 8'h00;
			{drv_en_q, pause_q, swap_q, to_mains_q} <= 4'h0;
			{idx_q, ptr_q, mover_q, cnt_q} <= 9'h000;
			ord_q <= '{2'h0, 2'h0, 2'h0, 2'h0};
			{term_q, relay_q} <= 2'b00;
		end else begin
			state_q <= state_d;
			{mains_q, drv_q} <= {mains_d, drv_d};
			{drv_en_q, pause_q, swap_q, to_mains_q} <=
				{drv_en_d, pause_d, swap_d, to_mains_d};
			{idx_q, ptr_q, mover_q, cnt_q} <= {idx_d, ptr_d, mover_d, cnt_d};
			ord_q <= ord_d;
			{term_q, relay_q} <= {term_lvl, relay_lvl};
		end
	end

	// selectable terminals follow their function codes
	mpcs_term_map u_out_map (.code(out_sel_q), .pause(pause_q),
		.mains(mains_q), .drive(drv_q), .level(term_lvl));
	mpcs_term_map u_relay_map (.code(relay_sel_q), .pause(pause_q),
		.mains(mains_q), .drive(drv_q), .level(relay_lvl));

	// outputs, all from flip-flops
	assign {s_axi_awready, s_axi_wready, s_axi_arready} =
		{awready_q, wready_q, arready_q};
	assign {s_axi_bvalid, s_axi_bresp} = {bvalid_q, bresp_q};
	assign {s_axi_rvalid, s_axi_rdata, s_axi_rresp} =
		{rvalid_q, rdata_q, rresp_q};
	assign {mains_contactor_m4, mains_contactor_m3, mains_contactor_m2,
		mains_contactor_m1} = mains_q;
	assign {drive_contactor_m4, drive_contactor_m3, drive_contactor_m2,
		drive_contactor_m1} = drv_q;
	assign {drive_output_en, output_pause} = {drv_en_q, pause_q};
	assign {output_terminal, relay_option_out} = {term_q, relay_q};

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_contactor_exclusive: assert property (
		(mains_q & drv_q) == 4'h0) else $error("both contactors closed");
	chk_basic_fixed_drive: assert property (
		scheme_q == SCH_BASIC && drv_q != 4'h0 |-> drv_q == 4'h1)
		else $error("basic scheme drive motor moved");
	chk_config_refused: assert property (
		wr_fire && awaddr_q == ADDR_CONFIG && running
		|=> bresp_q == RESP_SLVERR && $stable(aux_q) && $stable(scheme_q))
		else $error("config write taken while running");
	chk_order_restart: assert property (
		order_clr |=> ptr_q == 2'h0 && cnt_q == 3'h0 && state_q == ST_IDLE)
		else $error("starting order not restored");
	chk_enable_gate: assert property (
		!go |=> !drv_en_q && mains_q == 4'h0)
		else $error("running without enable");
	chk_pause_terminal: assert property (
		out_sel_q == CODE_PAUSE_HI |=> term_q == $past(pause_q))
		else $error("pause terminal wrong");
	chk_neg_code_refused: assert property (
		wr_fire && awaddr_q == ADDR_OUT_SEL && wstrb_q[0]
		&& wdata_q[7:0] >= CODE_NEG_M1 && wdata_q[7:0] <= CODE_NEG_M4
		|=> bresp_q == RESP_SLVERR && $stable(out_sel_q))
		else $error("active-low contactor code taken");
	chk_interlock_hold: assert property (
		state_q == ST_INTERLOCK && !il_exp && go && !order_clr
		|=> $stable(drv_q) && $stable(mains_q) && !drv_en_q)
		else $error("contactor moved during interlock");
	chk_start_wait: assert property (
		state_q == ST_WAIT_START && sw_exp && go && !order_clr
		|=> drv_en_q ##0 state_q == ST_RUN)
		else $error("drive not enabled after start wait");
	chk_pause_entry: assert property (
		state_q == ST_RUN && det_exp && go && !order_clr
		|=> pause_q && !drv_en_q ##1 pause_q)
		else $error("pause not entered");
	chk_no_aux: assert property (
		aux_q == 2'h0 |-> mains_q == 4'h0)
		else $error("mains motor with zero count");

	cov_transfer: cover property (state_q == ST_RUN ##1
		state_q == ST_INTERLOCK);
	cov_pause_swap: cover property (swap_q && state_q == ST_PAUSE);
	cov_ramp_back: cover property (state_q == ST_RAMP_DOWN ##1
		state_q == ST_INTERLOCK);
	cov_refused: cover property (bvalid_q && bresp_q == RESP_SLVERR);
endmodule

// ==== hdl/mpcs_term_map.sv ====
module mpcs_term_map
	import mpcs_pkg::*;
(
	input wire logic [7:0] code,
	input wire logic pause,
	input wire logic [3:0] mains,
	input wire logic [3:0] drive,
	output logic level
);
	// function code to terminal level; unknown codes stay low
	always_comb begin
		level = 1'b0;
		if (code == CODE_PAUSE_HI) begin
			level = pause;
		end else if (code == CODE_PAUSE_LO) begin
			level = !pause;
		end else if (code >= CODE_MAINS_M1 && code <= CODE_MAINS_M4) begin
			level = mains[2'(code - CODE_MAINS_M1)];
		end else if (code >= CODE_DRIVE_M1 && code <= CODE_DRIVE_M4) begin
			level = drive[2'(code - CODE_DRIVE_M1)];
		end
	end
endmodule

// ==== verification/mpcs_contactor_model.sv ====
// contactor bank and motors as seen from the sequencer's outputs
module mpcs_contactor_model
	import mpcs_pkg::*;
#(
	parameter int COAST = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] mains,
	input wire logic [3:0] drive,
	input wire logic drive_output_en,
	output logic drive_standstill,
	output logic weld_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	int coast_q;
	// coasting is never disabled, so the motor stops a while after output
	always_ff @(posedge aclk) begin
		coast_q <= drive_output_en ? 0 : coast_q + 1;
	end
	assign drive_standstill = coast_q > COAST;
	// a shorted motor stays recorded, mechanical interlock is not trusted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			weld_seen <= 1'b0;
		end else if (|(mains & drive)) begin
			weld_seen <= 1'b1;
		end
	end
endmodule

// ==== verification/tb.sv ====
module tb
	import mpcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CS = 10; // short second keeps the run brief
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic multi_pump_enable_in, start_cond, stop_cond, freq_below_level;
	logic pause_cancel, drive_standstill, weld_seen;
	logic mains_contactor_m1, mains_contactor_m2, mains_contactor_m3;
	logic mains_contactor_m4, drive_contactor_m1, drive_contactor_m2;
	logic drive_contactor_m3, drive_contactor_m4, drive_output_en;
	logic output_pause, output_terminal, relay_option_out;
	int n_mismatch = 0;
	int total_checks = 0;
	int n;
	mpcs_sequencer #(.CYC_SEC(CS)) i_mpcs_sequencer (.aclk, .aresetn,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .multi_pump_enable_in, .start_cond, .stop_cond,
		.freq_below_level, .pause_cancel, .drive_standstill,
		.mains_contactor_m1, .mains_contactor_m2, .mains_contactor_m3,
		.mains_contactor_m4, .drive_contactor_m1, .drive_contactor_m2,
		.drive_contactor_m3, .drive_contactor_m4, .drive_output_en,
		.output_pause, .output_terminal, .relay_option_out);
	mpcs_contactor_model i_mpcs_contactor_model (.aclk, .aresetn,
		.mains({mains_contactor_m4, mains_contactor_m3, mains_contactor_m2,
		mains_contactor_m1}), .drive({drive_contactor_m4, drive_contactor_m3,
		drive_contactor_m2, drive_contactor_m1}), .drive_output_en,
		.drive_standstill, .weld_seen);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic chk(input string s, input logic [31:0] g,
			input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %0h got %0h", s, e, g);
		end
	endtask
	// aw and w offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk("bresp", s_axi_bresp, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		chk("rresp", s_axi_rresp, e);
	endtask
	// bounded wait for a level; a timeout counts as a mismatch
	task automatic wt(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 300) begin
			@(posedge aclk);
			n++;
		end
		chk("wait", n < 300, 1);
	endtask
	task automatic t_regs();
		rd(ADDR_INTERLOCK, RESP_OKAY);
		chk("ilock", rdat, 32'h1);
		wr(ADDR_INTERLOCK, 32'h65, RESP_SLVERR);
		wr(ADDR_OUT_SEL, 32'hAB, RESP_SLVERR);
		wr(ADDR_RELAY_SEL, 32'hAA, RESP_SLVERR);
		rd(8'h24, RESP_DECERR);
		for (int c = 70; c <= 78; c++) begin
			wr(ADDR_OUT_SEL, c, RESP_OKAY);
		end
	endtask
	task automatic t_direct();
		wr(ADDR_OUT_SEL, 32'h47, RESP_OKAY);
		wr(ADDR_CONFIG, 32'h21, RESP_OKAY);
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		repeat (10) @(posedge aclk);
		chk("no enable", drive_contactor_m1, 0);
		multi_pump_enable_in <= 1'b0;
		wr(ADDR_IN_SEL, 32'hE, RESP_OKAY);
		repeat (10) @(posedge aclk);
		chk("enable low", drive_contactor_m1, 0);
		multi_pump_enable_in <= 1'b1;
		wt(drive_contactor_m1, 1);
		wt(drive_output_en, 1);
		chk("start wait", n >= CS, 1);
		wr(ADDR_CONFIG, 32'h10, RESP_SLVERR);
		start_cond <= 1'b1;
		wt(drive_contactor_m1, 0);
		wt(mains_contactor_m1, 1);
		chk("interlock", n >= CS, 1);
		start_cond <= 1'b0;
		wt(drive_contactor_m2, 1);
		chk("next drive", n < 3, 1);
		// terminal follows one cycle behind the contactor
		@(posedge aclk);
		chk("mains term", output_terminal, 1);
		chk("others", {mains_contactor_m4, mains_contactor_m3,
			drive_contactor_m4, drive_contactor_m3}, 0);
		stop_cond <= 1'b1;
		wt(mains_contactor_m1, 0);
		stop_cond <= 1'b0;
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
	endtask
	// two motors, so a swap has somewhere to go
	task automatic t_alt();
		wr(ADDR_CONFIG, 32'h11, RESP_OKAY);
		wr(ADDR_OUT_SEL, 32'h46, RESP_OKAY);
		wr(ADDR_RELAY_SEL, 32'h4C, RESP_OKAY);
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		wt(drive_contactor_m1, 1);
		// without the reset the rotation would pick motor two here
		wr(ADDR_CTRL, 32'h2, RESP_OKAY);
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		wt(drive_contactor_m1, 1);
		freq_below_level <= 1'b1;
		wt(output_pause, 1);
		@(posedge aclk);
		chk("pause out", output_terminal, 1);
		freq_below_level <= 1'b0;
		pause_cancel <= 1'b1;
		wt(drive_contactor_m2, 1);
		chk("old drive", drive_contactor_m1, 0);
		wt(output_pause, 0);
		pause_cancel <= 1'b0;
		chk("resume", drive_output_en, 1);
		chk("relay", relay_option_out, 1);
	endtask
	task automatic t_altdir();
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		wr(ADDR_CONFIG, 32'h31, RESP_OKAY);
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		wt(drive_output_en, 1);
		chk("first motor", drive_contactor_m1, 1);
		start_cond <= 1'b1;
		wt(mains_contactor_m1, 1);
		start_cond <= 1'b0;
		chk("next motor", drive_contactor_m2, 1);
		wt(drive_output_en, 1);
		stop_cond <= 1'b1;
		wt(drive_output_en, 0);
		stop_cond <= 1'b0;
		wt(mains_contactor_m1, 0);
		wt(drive_contactor_m1, 1);
		chk("back interlock", n >= CS, 1);
		chk("ramped off", drive_contactor_m2, 0);
	endtask
	task automatic t_basic();
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		wr(ADDR_CONFIG, 32'h01, RESP_OKAY);
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		start_cond <= 1'b1;
		wt(mains_contactor_m2, 1);
		start_cond <= 1'b0;
		chk("basic drive", drive_contactor_m1, 1);
		stop_cond <= 1'b1;
		wt(mains_contactor_m2, 0);
		stop_cond <= 1'b0;
		chk("basic kept", drive_contactor_m1, 1);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#500000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, start_cond, stop_cond} = '0;
		{freq_below_level, pause_cancel} = '0;
		multi_pump_enable_in = 1'b1;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_direct();
		t_alt();
		t_altdir();
		t_basic();
		chk("weld", weld_seen, 0);
		end_sim();
	end
endmodule
